/* bit_flag_unit.sv */
/*
  execution unit for rotates, shifts, nibble swap, io bit set/clear,
  transfer-flag moves and status flag set/clear, plus data access timing.
  assumes decoder supplies operands already read from register file and io space.
*/
`timescale 1ns/1ps
module bit_flag_unit
  import bitflag_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire issue_type ISSUE,
  input wire logic MEM_START,
  input wire mem_target_type MEM_TARGET,
  input wire logic [1:0] MEM_BASE_CYCLES,
  input wire logic MEM_EXT_READY,
  output result_type RESULT,
  output logic [DATA_W-1:0] STATUS_FLAGS,
  output logic DONE,
  output logic MEM_BUSY,
  output logic MEM_DONE
);

  logic [DATA_W-1:0] status_q, status_d;
  result_type result_q, result_d;
  logic done_q;
  logic [DATA_W-1:0] rd, res;
  logic c_in, c_out;

  assign rd = ISSUE.reg_data;
  assign c_in = status_q[FLAG_C];

  // datapath and flag next-state, one cycle for everything
  always_comb begin
    status_d = status_q;
    result_d = '0;
    res = rd;
    c_out = c_in;
    if (ISSUE.valid) begin
      case (ISSUE.op)
        OP_ROTATE_LEFT_CARRY: begin
          res = {rd[6:0], c_in};
          c_out = rd[7];
          status_d[FLAG_H] = rd[3];
        end
        OP_ROTATE_RIGHT_CARRY: begin
          res = {c_in, rd[7:1]};
          c_out = rd[0];
        end
        OP_ARITH_SHIFT_RIGHT: begin
          res = {rd[7], rd[7:1]};
          c_out = rd[0];
        end
        OP_NIBBLE_SWAP: res = {rd[3:0], rd[7:4]};
        OP_TRANSFER_FLAG_TO_BIT: res[ISSUE.bit_sel] = status_q[FLAG_T];
        default: res = rd;
      endcase
      case (ISSUE.op)
        OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT: begin
          // shifts share the z/c/n/v/s update; v is n xor c
          status_d[FLAG_C] = c_out;
          status_d[FLAG_Z] = (res == DATA_RESET);
          status_d[FLAG_N] = res[7];
          status_d[FLAG_V] = res[7] ^ c_out;
          status_d[FLAG_S] = c_out;
          result_d.reg_we = 1'b1;
        end
        OP_NIBBLE_SWAP, OP_TRANSFER_FLAG_TO_BIT: result_d.reg_we = 1'b1;
        OP_IO_BIT_SET: begin
          result_d.io_we = 1'b1;
          result_d.io_data = ISSUE.io_data | (8'h01 << ISSUE.bit_sel);
        end
        OP_IO_BIT_CLEAR: begin
          result_d.io_we = 1'b1;
          result_d.io_data = ISSUE.io_data & ~(8'h01 << ISSUE.bit_sel);
        end
        OP_BIT_TO_TRANSFER_FLAG: status_d[FLAG_T] = rd[ISSUE.bit_sel];
        OP_GENERIC_FLAG_SET: status_d[ISSUE.bit_sel] = 1'b1;
        OP_GENERIC_FLAG_CLEAR: status_d[ISSUE.bit_sel] = 1'b0;
        OP_OVERFLOW_FLAG_SET: status_d[FLAG_V] = 1'b1;
        OP_OVERFLOW_FLAG_CLEAR: status_d[FLAG_V] = 1'b0;
        OP_HALF_CARRY_SET: status_d[FLAG_H] = 1'b1;
        OP_HALF_CARRY_CLEAR: status_d[FLAG_H] = 1'b0;
        OP_SIGN_TEST_SET: status_d[FLAG_S] = 1'b1;
        OP_SIGN_TEST_CLEAR: status_d[FLAG_S] = 1'b0;
        OP_CARRY_SET: status_d[FLAG_C] = 1'b1;
        OP_CARRY_CLEAR: status_d[FLAG_C] = 1'b0;
        OP_NEGATIVE_SET: status_d[FLAG_N] = 1'b1;
        OP_NEGATIVE_CLEAR: status_d[FLAG_N] = 1'b0;
        OP_ZERO_SET: status_d[FLAG_Z] = 1'b1;
        OP_ZERO_CLEAR: status_d[FLAG_Z] = 1'b0;
        OP_INT_ENABLE: status_d[FLAG_I] = 1'b1;
        OP_INT_DISABLE: status_d[FLAG_I] = 1'b0;
        OP_TRANSFER_SET: status_d[FLAG_T] = 1'b1;
        OP_TRANSFER_CLEAR: status_d[FLAG_T] = 1'b0;
        default: result_d.reg_we = 1'b0;
      endcase
      result_d.reg_addr = ISSUE.reg_addr;
      result_d.reg_data = res;
      result_d.io_addr = ISSUE.io_addr;
      if (!result_d.io_we) begin
        result_d.io_data = DATA_RESET;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      status_q <= STATUS_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // results register so every output leaves a flop; no stall path needed
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      result_q <= '0;
      done_q <= 1'b0;
    end else begin
      result_q <= result_d;
      done_q <= ISSUE.valid;
    end
  end

  assign RESULT = result_q;
  assign STATUS_FLAGS = status_q;
  assign DONE = done_q;

  access_timer u_access_timer (
    .clk(CLK),
    .rst(SYS_RST),
    .start(MEM_START),
    .target(MEM_TARGET),
    .base_cycles(MEM_BASE_CYCLES),
    .ext_ready(MEM_EXT_READY),
    .busy_q(MEM_BUSY),
    .done_q(MEM_DONE)
  );

  AST_ROL_RESULT: assert property (@(posedge CLK) disable iff (SYS_RST)
    (ISSUE.valid && ISSUE.op == OP_ROTATE_LEFT_CARRY) |=>
    (RESULT.reg_data == {$past(rd[6:0]), $past(c_in)}) && STATUS_FLAGS[FLAG_C] == $past(rd[7]))
    else $error("rotate left result or carry wrong");
  AST_ROR_RESULT: assert property (@(posedge CLK) disable iff (SYS_RST)
    (ISSUE.valid && ISSUE.op == OP_ROTATE_RIGHT_CARRY) |=>
    (RESULT.reg_data == {$past(c_in), $past(rd[7:1])}) && STATUS_FLAGS[FLAG_C] == $past(rd[0]))
    else $error("rotate right result or carry wrong");
  AST_IO_SET: assert property (@(posedge CLK) disable iff (SYS_RST)
    (ISSUE.valid && ISSUE.op == OP_IO_BIT_SET) |=>
    RESULT.io_we && RESULT.io_data[$past(ISSUE.bit_sel)] && $stable(STATUS_FLAGS))
    else $error("io bit set wrong");
  AST_IO_CLR: assert property (@(posedge CLK) disable iff (SYS_RST)
    (ISSUE.valid && ISSUE.op == OP_IO_BIT_CLEAR) |=>
    RESULT.io_we && !RESULT.io_data[$past(ISSUE.bit_sel)] && $stable(STATUS_FLAGS))
    else $error("io bit clear wrong");
  AST_BST: assert property (@(posedge CLK) disable iff (SYS_RST)
    (ISSUE.valid && ISSUE.op == OP_BIT_TO_TRANSFER_FLAG) |=>
    STATUS_FLAGS[FLAG_T] == $past(rd[ISSUE.bit_sel]) && !RESULT.reg_we)
    else $error("bit store to transfer flag wrong");
  AST_BLD: assert property (@(posedge CLK) disable iff (SYS_RST)
    (ISSUE.valid && ISSUE.op == OP_TRANSFER_FLAG_TO_BIT) |=>
    RESULT.reg_data[$past(ISSUE.bit_sel)] == $past(status_q[FLAG_T]) && $stable(STATUS_FLAGS))
    else $error("bit load from transfer flag wrong");
  AST_SEV: assert property (@(posedge CLK) disable iff (SYS_RST)
    (ISSUE.valid && ISSUE.op == OP_OVERFLOW_FLAG_SET) |=>
    STATUS_FLAGS == ($past(status_q) | 8'h08))
    else $error("overflow set touched other flags");
  AST_CLV: assert property (@(posedge CLK) disable iff (SYS_RST)
    (ISSUE.valid && ISSUE.op == OP_OVERFLOW_FLAG_CLEAR) |=>
    STATUS_FLAGS == ($past(status_q) & 8'hF7))
    else $error("overflow clear touched other flags");
  AST_SEH: assert property (@(posedge CLK) disable iff (SYS_RST)
    (ISSUE.valid && ISSUE.op == OP_HALF_CARRY_SET) |=> STATUS_FLAGS == ($past(status_q) | 8'h20))
    else $error("half carry set wrong");
  AST_CLH: assert property (@(posedge CLK) disable iff (SYS_RST)
    (ISSUE.valid && ISSUE.op == OP_HALF_CARRY_CLEAR) |=> STATUS_FLAGS == ($past(status_q) & 8'hDF))
    else $error("half carry clear wrong");
  AST_SES: assert property (@(posedge CLK) disable iff (SYS_RST)
    (ISSUE.valid && ISSUE.op == OP_SIGN_TEST_SET) |=> STATUS_FLAGS == ($past(status_q) | 8'h10))
    else $error("sign test set wrong");
  AST_CLS: assert property (@(posedge CLK) disable iff (SYS_RST)
    (ISSUE.valid && ISSUE.op == OP_SIGN_TEST_CLEAR) |=> STATUS_FLAGS == ($past(status_q) & 8'hEF))
    else $error("sign test clear wrong");
  AST_ASR: assert property (@(posedge CLK) disable iff (SYS_RST)
    (ISSUE.valid && ISSUE.op == OP_ARITH_SHIFT_RIGHT) |=>
    RESULT.reg_data == {$past(rd[7]), $past(rd[7:1])})
    else $error("arith shift right wrong");
  AST_SWAP: assert property (@(posedge CLK) disable iff (SYS_RST)
    (ISSUE.valid && ISSUE.op == OP_NIBBLE_SWAP) |=>
    RESULT.reg_data == {$past(rd[3:0]), $past(rd[7:4])} && $stable(STATUS_FLAGS))
    else $error("nibble swap wrong");
  AST_GEN_SET: assert property (@(posedge CLK) disable iff (SYS_RST)
    (ISSUE.valid && ISSUE.op == OP_GENERIC_FLAG_SET) |=>
    STATUS_FLAGS == ($past(status_q) | (8'h01 << $past(ISSUE.bit_sel))))
    else $error("generic flag set wrong");
  AST_DONE_ONE: assert property (@(posedge CLK) disable iff (SYS_RST)
    ISSUE.valid |=> DONE)
    else $error("op did not finish in one cycle");

  COV_ROL: cover property (@(posedge CLK) ISSUE.valid && ISSUE.op == OP_ROTATE_LEFT_CARRY);
  COV_IO_SET: cover property (@(posedge CLK) ISSUE.valid && ISSUE.op == OP_IO_BIT_SET);
  COV_BST_BLD: cover property (@(posedge CLK)
    ISSUE.valid && ISSUE.op == OP_BIT_TO_TRANSFER_FLAG ##1 ISSUE.valid && ISSUE.op == OP_TRANSFER_FLAG_TO_BIT);
  COV_SRAM: cover property (@(posedge CLK) MEM_START && MEM_TARGET == MEM_INTERNAL_SRAM ##[1:4] MEM_DONE);

endmodule

/* bitflag_pkg.sv */
/*
  shared types and constants for the bit and flag execution unit.
  assumes a single 25 MHz core clock and a decoder that issues one op per cycle.
*/
package bitflag_pkg;

  localparam int DATA_W = 8;
  localparam int IO_ADDR_W = 6;
  localparam int REG_ADDR_W = 5;

  // status register bit positions
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // base cycle count used by the access timer when the table count is zero; internal sram costs one more
  localparam logic [1:0] BASE_CYCLES = 2'h1;
  localparam logic [1:0] SRAM_EXTRA_CYCLES = 2'h1;

  typedef enum logic [4:0] {
    OP_NONE,
    OP_ROTATE_LEFT_CARRY,
    OP_ROTATE_RIGHT_CARRY,
    OP_ARITH_SHIFT_RIGHT,
    OP_NIBBLE_SWAP,
    OP_GENERIC_FLAG_SET,
    OP_GENERIC_FLAG_CLEAR,
    OP_IO_BIT_SET,
    OP_IO_BIT_CLEAR,
    OP_BIT_TO_TRANSFER_FLAG,
    OP_TRANSFER_FLAG_TO_BIT,
    OP_OVERFLOW_FLAG_SET,
    OP_OVERFLOW_FLAG_CLEAR,
    OP_HALF_CARRY_SET,
    OP_HALF_CARRY_CLEAR,
    OP_SIGN_TEST_SET,
    OP_SIGN_TEST_CLEAR,
    OP_CARRY_SET,
    OP_CARRY_CLEAR,
    OP_NEGATIVE_SET,
    OP_NEGATIVE_CLEAR,
    OP_ZERO_SET,
    OP_ZERO_CLEAR,
    OP_INT_ENABLE,
    OP_INT_DISABLE,
    OP_TRANSFER_SET,
    OP_TRANSFER_CLEAR
  } op_type;

  typedef struct packed {
    logic valid;
    op_type op;
    logic [2:0] bit_sel;
    logic [REG_ADDR_W-1:0] reg_addr;
    logic [IO_ADDR_W-1:0] io_addr;
    logic [DATA_W-1:0] reg_data;
    logic [DATA_W-1:0] io_data;
  } issue_type;

  typedef struct packed {
    logic reg_we;
    logic [REG_ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_data;
    logic io_we;
    logic [IO_ADDR_W-1:0] io_addr;
    logic [DATA_W-1:0] io_data;
  } result_type;

  typedef enum logic [1:0] {
    MEM_ONCHIP_PERIPH,
    MEM_INTERNAL_SRAM,
    MEM_EXTERNAL
  } mem_target_type;

endpackage

/* access_timer.sv */
/*
  cycle counter for data memory accesses issued by the core.
  assumes the requester holds start for one cycle and waits for done.
*/
`timescale 1ns/1ps
module access_timer
  import bitflag_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire mem_target_type target,
  input wire logic [1:0] base_cycles,
  input wire logic ext_ready,
  output logic busy_q,
  output logic done_q
);

  logic [2:0] count_q;
  logic ext_q;
  logic [1:0] base_eff;

  // a zero table count is taken as one, so sram still costs one more
  assign base_eff = (base_cycles == 2'h0) ? BASE_CYCLES : base_cycles;

  always_ff @(posedge clk) begin
    if (rst) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      count_q <= 3'h0;
      ext_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start && !busy_q) begin
        busy_q <= 1'b1;
        ext_q <= (target == MEM_EXTERNAL);
        // sram adds one cycle to the table count
        if (target == MEM_INTERNAL_SRAM) begin
          count_q <= {1'b0, base_eff} + {1'b0, SRAM_EXTRA_CYCLES};
        end else begin
          count_q <= {1'b0, base_eff};
        end
      end else if (busy_q) begin
        // external bus ignores the table count and waits on its ready
        if (ext_q) begin
          if (ext_ready) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        end else if (count_q <= 3'h1) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          count_q <= count_q - 3'h1;
        end
      end
    end
  end

  AST_SRAM_LONGER: assert property (@(posedge clk) disable iff (rst)
    (start && !busy_q && target == MEM_INTERNAL_SRAM && base_cycles == 2'h1) |=> !done_q ##1 !done_q ##1 done_q)
    else $error("sram access did not take one extra cycle");
  AST_EXT_WAITS: assert property (@(posedge clk) disable iff (rst)
    (busy_q && ext_q && !ext_ready) |=> !done_q)
    else $error("external access finished without ready");

endmodule

/* operand_model.sv */
/*
  far-side model: register file, io space and external memory ready.
  assumes the bench preloads through pre_* and results land one cycle after issue.
*/
`timescale 1ns/1ps
module operand_model
  import bitflag_pkg::*;
(
  input wire logic clk,
  input wire issue_type req,
  input wire result_type res,
  input wire logic pre_we,
  input wire logic pre_io,
  input wire logic [5:0] pre_addr,
  input wire logic [7:0] pre_data,
  input wire logic busy,
  input wire logic ext,
  input wire logic [3:0] ext_delay,
  output issue_type issue,
  output logic ext_ready
);
  logic [7:0] rf [32];
  logic [7:0] io [64];
  logic [3:0] cnt_q = 4'h0;
  logic tog_q = 1'b0;
  always_comb begin
    issue = req;
    // forwarding, so op n+1 reads what op n wrote
    issue.reg_data = (res.reg_we && res.reg_addr == req.reg_addr) ? res.reg_data : rf[req.reg_addr];
    issue.io_data = (res.io_we && res.io_addr == req.io_addr) ? res.io_data : io[req.io_addr];
  end
  always_ff @(posedge clk) begin
    if (pre_we && !pre_io) rf[pre_addr[4:0]] <= pre_data;
    if (pre_we && pre_io) io[pre_addr] <= pre_data;
    if (res.reg_we) rf[res.reg_addr] <= res.reg_data;
    if (res.io_we) io[res.io_addr] <= res.io_data;
  end
  always_ff @(posedge clk) begin
    cnt_q <= busy ? cnt_q + 4'h1 : 4'h0;
    tog_q <= !tog_q;
  end
  // meaningless outside an external access, so it toggles there
  assign ext_ready = (busy && ext) ? (cnt_q >= ext_delay) : tog_q;
endmodule

/* bit_flag_unit_tb.sv */
/*
  self-checking bench for the bit and flag execution unit.
  assumes the operand model supplies operands and ext ready.
*/
`timescale 1ns/1ps
module bit_flag_unit_tb
  import bitflag_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  issue_type req, issue;
  result_type res;
  logic [7:0] flags, pre_data, f;
  logic done, mem_start, mem_busy, mem_done, ext_ready, pre_we, pre_io;
  mem_target_type target;
  logic [1:0] base;
  logic [5:0] pre_addr;
  logic [3:0] ext_delay;
  logic [7:0] rf [32];
  logic [7:0] io [64];
  logic [7:0] rv [8] = '{8'h81, 8'h00, 8'h08, 8'h01, 8'h7F, 8'h80, 8'hFF, 8'h3C};
  logic [2:0] fx [8] = '{FLAG_V, FLAG_H, FLAG_S, FLAG_C, FLAG_N, FLAG_Z, FLAG_I, FLAG_T};
  int failures = 0;
  int cmp_count = 0;
  int n1, n2, k;
  always #20 clk = !clk;
  bit_flag_unit u_bit_flag_unit (.CLK(clk), .SYS_RST(rst), .ISSUE(issue), .MEM_START(mem_start),
    .MEM_TARGET(target), .MEM_BASE_CYCLES(base), .MEM_EXT_READY(ext_ready), .RESULT(res),
    .STATUS_FLAGS(flags), .DONE(done), .MEM_BUSY(mem_busy), .MEM_DONE(mem_done));
  operand_model u_operand_model (.clk(clk), .req(req), .res(res), .pre_we(pre_we), .pre_io(pre_io),
    .pre_addr(pre_addr), .pre_data(pre_data), .busy(mem_busy), .ext(target == MEM_EXTERNAL),
    .ext_delay(ext_delay), .issue(issue), .ext_ready(ext_ready));
  task finish_test;
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task chk_res(input result_type got, input result_type exp);
    result_type g;
    g = got;
    // fields behind a low write enable carry no meaning
    if (!exp.reg_we) {g.reg_addr, g.reg_data} = '0;
    if (!exp.io_we) {g.io_addr, g.io_data} = '0;
    cmp_count++;
    if (g !== exp) begin
      failures++;
      $display("wrong value at %0t: result %h exp %h", $time, got, exp);
    end
  endtask
  task op(input op_type o, input logic [2:0] b, input logic [4:0] ra, input logic [5:0] ia);
    logic [7:0] d, r, x;
    result_type e;
    d = rf[ra];
    x = io[ia];
    r = d;
    e = '0;
    case (o)
      OP_ROTATE_LEFT_CARRY: begin
        r = {d[6:0], f[FLAG_C]};
        f[FLAG_C] = d[7];
        f[FLAG_H] = d[3];
      end
      OP_ROTATE_RIGHT_CARRY: begin
        r = {f[FLAG_C], d[7:1]};
        f[FLAG_C] = d[0];
      end
      OP_ARITH_SHIFT_RIGHT: begin
        r = {d[7], d[7:1]};
        f[FLAG_C] = d[0];
      end
      OP_NIBBLE_SWAP: r = {d[3:0], d[7:4]};
      OP_GENERIC_FLAG_SET: f[b] = 1'b1;
      OP_GENERIC_FLAG_CLEAR: f[b] = 1'b0;
      OP_IO_BIT_SET: x[b] = 1'b1;
      OP_IO_BIT_CLEAR: x[b] = 1'b0;
      OP_BIT_TO_TRANSFER_FLAG: f[FLAG_T] = d[b];
      OP_TRANSFER_FLAG_TO_BIT: r[b] = f[FLAG_T];
      OP_NONE: ;
      // dedicated set/clear pairs, set on the odd code
      default: f[fx[(int'(o) - 11) / 2]] = o[0];
    endcase
    if (int'(o) inside {[1:3]}) begin
      f[FLAG_Z] = (r == 8'h00);
      f[FLAG_N] = r[7];
      f[FLAG_V] = r[7] ^ f[FLAG_C];
      f[FLAG_S] = f[FLAG_N] ^ f[FLAG_V];
    end
    e.reg_we = int'(o) inside {[1:4], 10};
    e.io_we = o inside {OP_IO_BIT_SET, OP_IO_BIT_CLEAR};
    if (e.reg_we) {e.reg_addr, e.reg_data, rf[ra]} = {ra, r, r};
    if (e.io_we) {e.io_addr, e.io_data, io[ia]} = {ia, x, x};
    req = '{1'b1, o, b, ra, ia, 8'h00, 8'h00};
    @(posedge clk);
    #1;
    chk_res(res, e);
    chk8(flags, f);
    chk8({7'h0, done}, 8'h01);
  endtask
  task idle;
    req.valid = 1'b0;
    @(posedge clk);
    #1;
    chk8({7'h0, done}, 8'h00);
  endtask
  task mem(input mem_target_type t, input logic [1:0] bs, input logic [3:0] dl, output int n);
    target = t;
    {base, ext_delay, mem_start} = {bs, dl, 1'b1};
    @(posedge clk);
    #1;
    mem_start = 1'b0;
    n = 1;
    chk8({7'h0, mem_busy}, 8'h01);
    while (mem_done !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
  endtask
  initial begin
    req = '0;
    {mem_start, base, ext_delay, pre_we, pre_io, pre_addr, pre_data} = '0;
    target = MEM_ONCHIP_PERIPH;
    f = STATUS_RESET;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    chk8(flags, STATUS_RESET);
    chk8({6'h0, done, mem_busy}, 8'h00);
    for (k = 0; k < 16; k++) begin
      {pre_we, pre_io, pre_addr} = {1'b1, k[3], 3'h0, k[2:0]};
      pre_data = k[3] ? ~rv[k[2:0]] : rv[k[2:0]];
      if (k[3]) io[k[2:0]] = pre_data;
      else rf[k[2:0]] = pre_data;
      @(posedge clk);
      #1;
    end
    pre_we = 1'b0;
    op(OP_ROTATE_LEFT_CARRY, 3'h0, 5'h0, 6'h0);
    op(OP_ROTATE_LEFT_CARRY, 3'h0, 5'h0, 6'h0);
    op(OP_ROTATE_LEFT_CARRY, 3'h0, 5'h2, 6'h0);
    op(OP_ROTATE_RIGHT_CARRY, 3'h0, 5'h3, 6'h0);
    op(OP_ROTATE_RIGHT_CARRY, 3'h0, 5'h1, 6'h0);
    op(OP_ARITH_SHIFT_RIGHT, 3'h0, 5'h5, 6'h0);
    op(OP_ARITH_SHIFT_RIGHT, 3'h0, 5'h4, 6'h0);
    op(OP_NIBBLE_SWAP, 3'h0, 5'h7, 6'h0);
    for (k = 0; k < 16; k++) op(k[0] ? OP_IO_BIT_CLEAR : OP_IO_BIT_SET, k[3:1], 5'h0, 6'h5);
    for (k = 0; k < 16; k++) op(k[0] ? OP_TRANSFER_FLAG_TO_BIT : OP_BIT_TO_TRANSFER_FLAG, k[3:1], {4'h0, ~k[0]}, 6'h0);
    for (k = 0; k < 16; k++) op(k[3] ? OP_GENERIC_FLAG_CLEAR : OP_GENERIC_FLAG_SET, k[2:0], 5'h0, 6'h0);
    for (k = 0; k < 16; k++) op(op_type'(11 + 2 * (k % 8) + k / 8), 3'h0, 5'h0, 6'h0);
    op(OP_INT_ENABLE, 3'h0, 5'h0, 6'h0);
    op(OP_NONE, 3'h0, 5'h0, 6'h0);
    idle;
    // reset in mid-run clears the flags again
    rst = 1'b1;
    @(posedge clk);
    #1 rst = 1'b0;
    f = STATUS_RESET;
    chk8(flags, f);
    mem(MEM_INTERNAL_SRAM, 2'h1, 4'h0, n1);
    chk8(8'(n1), 8'h03);
    for (k = 0; k < 4; k++) begin
      mem(MEM_ONCHIP_PERIPH, k[1:0], 4'h0, n1);
      mem(MEM_INTERNAL_SRAM, k[1:0], 4'h0, n2);
      chk8(8'(n2 - n1), 8'h01);
    end
    mem(MEM_EXTERNAL, 2'h1, 4'h2, n1);
    mem(MEM_EXTERNAL, 2'h1, 4'h6, n2);
    chk8(8'(n2 - n1), 8'h04);
    finish_test;
  end
  initial begin
    // about 150 cycles expected, generous margin
    #(40 * 2000);
    failures++;
    finish_test;
  end
endmodule
